// *** hw/soel_consts.svh ***
// soel_consts.svh: register map, field positions, reset values and timing counts
`ifndef SOEL_CONSTS_SVH
`define SOEL_CONSTS_SVH

// ==========================================
// register byte addresses
`define SOEL_ADDR_CTRL 8'h00
`define SOEL_ADDR_SWTIME 8'h04
`define SOEL_ADDR_EXPCODE 8'h08
`define SOEL_ADDR_STATE 8'h0C
`define SOEL_ADDR_IRQ_STS 8'h10
`define SOEL_ADDR_IRQ_MASK 8'h14

// ==========================================
// control fields
`define SOEL_CTRL_RUN 0
`define SOEL_CTRL_MONSTART 1
`define SOEL_CTRL_RST 2'h0
`define SOEL_SWTIME_RST 16'h0064
`define SOEL_EXPCODE_RST 4'hF

// ==========================================
// state register fields
`define SOEL_ST_OUT 0
`define SOEL_ST_LOCK 1
`define SOEL_ST_FB 2
`define SOEL_ST_CH0 3
`define SOEL_ST_CH1 4
`define SOEL_ST_START 5
`define SOEL_ST_PHASE 8

// ==========================================
// interrupt status bits
`define SOEL_IRQ_ON 0
`define SOEL_IRQ_OFF 1
`define SOEL_IRQ_FBFAULT 2
`define SOEL_IRQ_CODEERR 3
`define SOEL_IRQ_W 4

// ==========================================
// bus answers
`define SOEL_RESP_OKAY 2'h0
`define SOEL_RESP_SLVERR 2'h2

// ==========================================
// timing: switching time counts in milliseconds
`define SOEL_CLK_PERIOD_NS 20
`define SOEL_MS_NS 1000000
`define SOEL_MS_CYCLES ((`SOEL_MS_NS) / (`SOEL_CLK_PERIOD_NS))

`endif

// *** hw/soel_pkg.sv ***
// soel_pkg.sv: types shared by the safety output enable logic
package soel_pkg;

    // ==========================================
    // output channel phases
    typedef enum logic [1:0] {
        SOEL_OFF_SETTLE,
        SOEL_OFF_READY,
        SOEL_ON_SETTLE,
        SOEL_ON_RUN
    } soel_phase_t;

endpackage

// *** hw/soel_sync.sv ***
// soel_sync.sv: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module soel_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level <= RST_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // change accepted only once stages two and three agree
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end
endmodule // soel_sync

`default_nettype wire

// *** hw/soel_top.sv ***
// soel_top.sv: safety output channel enable logic with AXI4-Lite registers
//
// Function
// - while the channel is off, feedback must be ON before enabling is allowed.
// - for the switching time after enabling, the feedback input is ignored.
// - after that time, feedback must stay OFF for as long as the channel is on.
// - for the switching time after switching off, the feedback input is not evaluated.
// - after that time, feedback is expected to be ON again.
// - while feedback says the contactor is not at rest, re-enabling is blocked.
// - right after power-up, feedback must be ON.
// - with monitored start, a start input activation is needed before enabling.
// - enabling happens only when all monitoring and feedback terms and start are met.
// - the signalling output and the output circuit switch on in the same cycle.
// - when the enable condition drops, both outputs switch off at once.
// - each switch signal governs its own two code bits, each channel checked alone.
// - no synchronisation window is imposed between the two channels.
// - each poll compares received and expected code; mismatch or timeout switches off.
`include "soel_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module soel_top #(
    parameter int MS_CYCLES = `SOEL_MS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // safe slave poll results, same clock domain
    input wire logic poll_valid,
    input wire logic [3:0] poll_code,
    input wire logic poll_timeout,
    // pins
    input wire logic feedback_in,
    input wire logic start_in,
    output logic safety_output_channel,
    output logic signal_out,
    output logic irq
);
    import soel_pkg::*;

    // refuse a prescaler the millisecond counter cannot serve
    if (MS_CYCLES < 1) begin : g_ms_check
        $error("soel_top: MS_CYCLES must be at least one");
    end

    // ==========================================
    // pin synchronisers
    logic fb;
    logic start_lvl;
    logic start_prev_r;

    // feedback resets high so power-up does not trip before the pin is seen
    soel_sync #(.RST_VAL(1'b1)) u_sync_fb (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(feedback_in),
        .level(fb)
    );

    soel_sync #(.RST_VAL(1'b0)) u_sync_start (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(start_in),
        .level(start_lvl)
    );

    wire start_rise = start_lvl & ~start_prev_r;

    // ==========================================
    // registers
    logic [1:0] ctrl_r;
    logic [15:0] swtime_r;
    logic [3:0] expcode_r;
    logic [`SOEL_IRQ_W-1:0] irq_sts_r;
    logic [`SOEL_IRQ_W-1:0] irq_mask_r;

    // ==========================================
    // code evaluation
    logic [1:0] ch_ok_r;
    wire [1:0] ch_match = {poll_code[3:2] == expcode_r[3:2], poll_code[1:0] == expcode_r[1:0]};
    // mismatch or timeout drops the channel
    wire code_err = poll_timeout | (poll_valid & ~(&ch_match));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_ok_r <= 2'h0;
        end else if (poll_timeout) begin
            ch_ok_r <= 2'h0;
        end else if (poll_valid) begin
            // each channel updates alone, no pairing window
            ch_ok_r <= ch_match;
        end
    end

    // ==========================================
    // switching time
    logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_r;
    logic [15:0] sw_cnt_r;
    logic sw_load;
    wire ms_tick = (ms_cnt_r == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
    wire sw_done = (sw_cnt_r == 16'h0000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt_r <= '0;
            sw_cnt_r <= 16'h0000;
        end else begin
            ms_cnt_r <= (ms_tick || sw_load) ? '0 : ms_cnt_r + 1'b1;
            if (sw_load) begin
                sw_cnt_r <= swtime_r;
            end else if (ms_tick && !sw_done) begin
                sw_cnt_r <= sw_cnt_r - 16'h0001;
            end
        end
    end

    // ==========================================
    // phase machine
    soel_phase_t phase_r;
    soel_phase_t phase_nxt;
    logic out_r;
    logic out_nxt;
    logic lock_r;
    logic lock_nxt;
    logic fb_fault;

    wire run_en = ctrl_r[`SOEL_CTRL_RUN];
    wire mon_start = ctrl_r[`SOEL_CTRL_MONSTART];
    // start press needed when monitored start is on
    wire start_ok = mon_start ? start_rise : 1'b1;
    wire mon_ok = run_en & (&ch_ok_r) & ~code_err;
    // new start sequence lifts the lock
    wire lock_clear = lock_r & fb & start_ok;

    always_comb begin
        phase_nxt = phase_r;
        out_nxt = out_r;
        lock_nxt = lock_r;
        sw_load = 1'b0;
        fb_fault = 1'b0;
        case (phase_r)
            SOEL_OFF_SETTLE: begin
                if (sw_done) begin
                    phase_nxt = SOEL_OFF_READY;
                end
            end
            SOEL_OFF_READY: begin
                if (lock_clear) begin
                    lock_nxt = 1'b0;
                end
                if (!fb) begin
                    fb_fault = 1'b1;
                    lock_nxt = 1'b1;
                end else if (mon_ok && start_ok && (!lock_r || !mon_start)) begin
                    lock_nxt = 1'b0;
                    out_nxt = 1'b1;
                    sw_load = 1'b1;
                    phase_nxt = SOEL_ON_SETTLE;
                end
            end
            SOEL_ON_SETTLE: begin
                if (!mon_ok) begin
                    out_nxt = 1'b0;
                    sw_load = 1'b1;
                    phase_nxt = SOEL_OFF_SETTLE;
                // feedback ignored until time runs out
                end else if (sw_done) begin
                    phase_nxt = SOEL_ON_RUN;
                end
            end
            SOEL_ON_RUN: begin
                // feedback must stay off while on
                if (fb) begin
                    fb_fault = 1'b1;
                    lock_nxt = 1'b1;
                end
                if (!mon_ok || fb) begin
                    out_nxt = 1'b0;
                    sw_load = 1'b1;
                    phase_nxt = SOEL_OFF_SETTLE;
                end
            end
            default: begin
                out_nxt = 1'b0;
                phase_nxt = SOEL_OFF_READY;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // start in the ready phase demanding feedback on
            phase_r <= SOEL_OFF_READY;
            out_r <= 1'b0;
            lock_r <= 1'b0;
            start_prev_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            out_r <= out_nxt;
            lock_r <= lock_nxt;
            start_prev_r <= start_lvl;
        end
    end

    assign safety_output_channel = out_r;
    assign signal_out = out_r;

    // ==========================================
    // axi4-lite write channel
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready = ~w_have_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    wire wr_go = aw_have_r & w_have_r;
    wire wr_ctrl = wr_go & (aw_addr_r == `SOEL_ADDR_CTRL);
    wire wr_swtime = wr_go & (aw_addr_r == `SOEL_ADDR_SWTIME);
    wire wr_exp = wr_go & (aw_addr_r == `SOEL_ADDR_EXPCODE);
    wire wr_mask = wr_go & (aw_addr_r == `SOEL_ADDR_IRQ_MASK);
    wire wr_known = wr_ctrl | wr_swtime | wr_exp | wr_mask
        | (aw_addr_r == `SOEL_ADDR_STATE) | (aw_addr_r == `SOEL_ADDR_IRQ_STS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `SOEL_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? `SOEL_RESP_OKAY : `SOEL_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `SOEL_CTRL_RST;
            swtime_r <= `SOEL_SWTIME_RST;
            expcode_r <= `SOEL_EXPCODE_RST;
            irq_mask_r <= '0;
        end else begin
            if (wr_ctrl && w_strb_r[0]) begin
                ctrl_r <= w_data_r[1:0];
            end
            if (wr_swtime && w_strb_r[0]) begin
                swtime_r[7:0] <= w_data_r[7:0];
            end
            if (wr_swtime && w_strb_r[1]) begin
                swtime_r[15:8] <= w_data_r[15:8];
            end
            if (wr_exp && w_strb_r[0]) begin
                expcode_r <= w_data_r[3:0];
            end
            if (wr_mask && w_strb_r[0]) begin
                irq_mask_r <= w_data_r[`SOEL_IRQ_W-1:0];
            end
        end
    end

    // ==========================================
    // axi4-lite read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    wire rd_go = s_axi_arvalid & ~rvalid_r;
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
    wire rd_sts = rd_go & (rd_addr == `SOEL_ADDR_IRQ_STS);
    wire [31:0] state_word = {22'h000000, 2'(phase_r), 2'b00, start_lvl, ch_ok_r, fb,
        lock_r, out_r};
    wire rd_known = (rd_addr == `SOEL_ADDR_CTRL) | (rd_addr == `SOEL_ADDR_SWTIME)
        | (rd_addr == `SOEL_ADDR_EXPCODE) | (rd_addr == `SOEL_ADDR_STATE)
        | (rd_addr == `SOEL_ADDR_IRQ_STS) | (rd_addr == `SOEL_ADDR_IRQ_MASK);
    wire [31:0] rd_word =
        (rd_addr == `SOEL_ADDR_CTRL) ? {30'h00000000, ctrl_r} :
        (rd_addr == `SOEL_ADDR_SWTIME) ? {16'h0000, swtime_r} :
        (rd_addr == `SOEL_ADDR_EXPCODE) ? {28'h0000000, expcode_r} :
        (rd_addr == `SOEL_ADDR_STATE) ? state_word :
        (rd_addr == `SOEL_ADDR_IRQ_STS) ? {28'h0000000, irq_sts_r} :
        (rd_addr == `SOEL_ADDR_IRQ_MASK) ? {28'h0000000, irq_mask_r} : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `SOEL_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_known ? `SOEL_RESP_OKAY : `SOEL_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================
    // interrupts: read clears, a new event in the same cycle survives
    wire [`SOEL_IRQ_W-1:0] irq_set = {code_err, fb_fault, out_r & ~out_nxt, ~out_r & out_nxt};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_sts_r <= '0;
        end else begin
            irq_sts_r <= (rd_sts ? '0 : irq_sts_r) | irq_set;
        end
    end

    assign irq = |(irq_sts_r & irq_mask_r);

endmodule // soel_top

`default_nettype wire

// *** test/soel_top_properties.sv ***
// soel_top_properties.sv: port-level checks of the enable logic
`timescale 1ns/1ns
`default_nettype none
module soel_top_properties #(
    parameter int MS_CYCLES = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic poll_valid,
    input wire logic [3:0] poll_code,
    input wire logic poll_timeout,
    input wire logic feedback_in,
    input wire logic safety_output_channel,
    input wire logic signal_out
);
    // switching time stays at its reset value, expected code stays 4'hF
    localparam int SW = 100 * MS_CYCLES;
    localparam int LIM = SW + MS_CYCLES + 8;
    wire logic q = safety_output_channel;
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic [3:0] fb_hi;
    logic [5:0] fb_h;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // helper counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_cnt <= 16'h0;
            off_cnt <= 16'hFFFF;
            fb_hi <= 4'h0;
            fb_h <= 6'h0;
        end else begin
            on_cnt <= !q ? 16'h0 : (&on_cnt ? on_cnt : on_cnt + 16'h1);
            off_cnt <= q ? 16'h0 : (&off_cnt ? off_cnt : off_cnt + 16'h1);
            fb_hi <= !feedback_in ? 4'h0 : (&fb_hi ? fb_hi : fb_hi + 4'h1);
            fb_h <= {fb_h[4:0], feedback_in};
        end
    end
    // ==========================================
    // properties
    property p_pair; q == signal_out; endproperty
    a_pair: assert property (p_pair) else $error("outputs differ");
    property p_tmo; poll_timeout |=> !q; endproperty
    a_tmo: assert property (p_tmo) else $error("on after timeout");
    property p_code; poll_valid && poll_code != 4'hF |=> !q; endproperty
    a_code: assert property (p_code) else $error("on after bad code");
    property p_rise; $rose(q) |-> fb_h != 6'h0; endproperty
    a_rise: assert property (p_rise) else $error("on without feedback");
    property p_fbon; on_cnt > LIM |-> fb_hi < 4'h8; endproperty
    a_fbon: assert property (p_fbon) else $error("feedback high while on");
    property p_offt; $rose(q) |-> off_cnt >= SW; endproperty
    a_offt: assert property (p_offt) else $error("on during off settle");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule // soel_top_properties
`default_nettype wire

// *** test/soel_partner.sv ***
// soel_partner.sv: contactor, start-free slave poll model
`timescale 1ns/1ns
`default_nettype none
module soel_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic coil,
    input wire logic [1:0] fb_mode,
    input wire logic [3:0] code,
    input wire logic to_req,
    output logic poll_valid,
    output logic [3:0] poll_code,
    output logic poll_timeout,
    output logic feedback_in
);
    logic [2:0] arm_r;
    logic [2:0] slot_r;
    always_ff @(posedge aclk) begin
        arm_r <= aresetn ? {arm_r[1:0], coil} : 3'h0;
        slot_r <= aresetn ? slot_r + 3'h1 : 3'h0;
        poll_valid <= aresetn && slot_r == 3'h0 && !to_req;
        poll_timeout <= aresetn && slot_r == 3'h0 && to_req;
        poll_code <= slot_r == 3'h0 ? code : ~poll_code;
    end
    // rest contact closes feedback; modes weld or break it
    assign feedback_in = fb_mode == 2'h1 ? 1'b0 : (fb_mode == 2'h2 ? 1'b1 : !arm_r[2]);
endmodule // soel_partner
`default_nettype wire

// *** test/tb_soel_top.sv ***
// tb_soel_top.sv: self-checking bench of the enable logic
`include "soel_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_soel_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [1:0] fb_mode = 2'h1;
    logic [3:0] code = 4'hF;
    logic to_req = 1'b0, start_in = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pv, pt, fb, out, sig, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] pc;
    int fail_count = 0, compares = 0, cyc = 0, bad;
    soel_top #(.MS_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .poll_valid(pv), .poll_code(pc), .poll_timeout(pt),
        .feedback_in(fb), .start_in(start_in), .safety_output_channel(out),
        .signal_out(sig), .irq(irq));
    soel_partner u_far (.aclk(aclk), .aresetn(aresetn), .coil(out), .fb_mode(fb_mode),
        .code(code), .to_req(to_req), .poll_valid(pv), .poll_code(pc),
        .poll_timeout(pt), .feedback_in(fb));
    always #10 aclk = ~aclk;
    // ==========================================
    // helpers
    task end_of_test();
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fail_count++;
            end_of_test();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task wait_out(input logic v, input int lim);
        for (int n = 0; n < lim && out !== v; n++) @(negedge aclk);
        chk("out", 32'(v), 32'(out));
        @(posedge aclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ka, kw, kb;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(negedge aclk);
            ka = awvalid && awready;
            kw = wvalid && wready;
            kb = bready && bvalid;
            r = bresp;
            @(posedge aclk);
            if (ka) awvalid <= 1'b0;
            if (kw) wvalid <= 1'b0;
            if (kb) begin
                bready <= 1'b0;
                break;
            end else if (bvalid) bready <= 1'b1;
        end
        chk("bresp", 32'h0, 32'(r));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ka, kb;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(negedge aclk);
            ka = arvalid && arready;
            kb = rready && rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ka) arvalid <= 1'b0;
            if (kb) begin
                rready <= 1'b0;
                break;
            end else if (rvalid) rready <= 1'b1;
        end
        chk("rdata", ed, d);
        chk("rresp", 32'(er), 32'(r));
    endtask
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h1ff61e3d));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SOEL_ADDR_SWTIME, 32'h64, 2'h0);
        wr(`SOEL_ADDR_CTRL, 32'h1);
        repeat (60) @(posedge aclk);
        chk("out", 32'h0, 32'(out));
        rd(`SOEL_ADDR_IRQ_STS, 32'h4, 2'h0);
        rd(`SOEL_ADDR_STATE, 32'h11A, 2'h0);
        $display("test power_up done");
        fb_mode <= 2'h0;
        wait_out(1'b1, 40);
        chk("sig", 32'h1, 32'(sig));
        rd(`SOEL_ADDR_IRQ_STS, 32'h5, 2'h0);
        fb_mode <= 2'h2;
        repeat (300) @(posedge aclk);
        chk("out", 32'h1, 32'(out));
        fb_mode <= 2'h0;
        repeat (130) @(posedge aclk);
        chk("out", 32'h1, 32'(out));
        fb_mode <= 2'h2;
        wait_out(1'b0, 10);
        rd(`SOEL_ADDR_IRQ_STS, 32'h6, 2'h0);
        fb_mode <= 2'h0;
        repeat (350) @(posedge aclk);
        chk("out", 32'h0, 32'(out));
        wait_out(1'b1, 200);
        $display("test feedback done");
        for (int i = 0; i < 2; i++) begin
            bad = $urandom % 3;
            code <= i[0] ? {bad[1:0], 2'h3} : {2'h3, bad[1:0]};
            wait_out(1'b0, 30);
            code <= 4'hF;
            wait_out(1'b1, 600);
        end
        $display("test code done");
        wr(`SOEL_ADDR_CTRL, 32'h3);
        to_req <= 1'b1;
        wait_out(1'b0, 30);
        to_req <= 1'b0;
        repeat (600) @(posedge aclk);
        chk("out", 32'h0, 32'(out));
        start_in <= 1'b1;
        repeat (10) @(posedge aclk);
        start_in <= 1'b0;
        wait_out(1'b1, 30);
        $display("test start done");
        wr(`SOEL_ADDR_IRQ_MASK, 32'h2);
        rd(`SOEL_ADDR_IRQ_STS, 32'hB, 2'h0);
        @(negedge aclk);
        chk("irq", 32'h0, 32'(irq));
        wr(`SOEL_ADDR_CTRL, 32'h0);
        wait_out(1'b0, 4);
        @(negedge aclk);
        chk("irq", 32'h1, 32'(irq));
        rd(`SOEL_ADDR_IRQ_STS, 32'h2, 2'h0);
        @(negedge aclk);
        chk("irq", 32'h0, 32'(irq));
        rd(8'h40, 32'h0, 2'h2);
        $display("test irq done");
        end_of_test();
    end
endmodule // tb_soel_top
bind soel_top soel_top_properties #(.MS_CYCLES(MS_CYCLES)) u_props (.aclk, .aresetn,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .poll_valid, .poll_code, .poll_timeout, .feedback_in, .safety_output_channel, .signal_out);
`default_nettype wire
